// ### rtl/fiosr_pkg.sv
// constants and types shared by the field i/o status register bank
package fiosr_pkg;
   localparam logic [15:0] REG_COMM_ADDR  = 16'h9c41;   // holding register 40001
   localparam logic [15:0] REG_STATE_ADDR = 16'h9c42;   // holding register 40002
   localparam logic [15:0] COMM_RESET     = 16'h0300;   // 38400 baud, no added pause
   localparam int          BAUD_LSB       = 8;
   localparam int          DELAY_LSB      = 0;
   localparam int          BIT_REMOTE     = 15;
   localparam int          BIT_ACT        = 14;
   localparam int          BIT_RET        = 13;
   localparam int          BIT_THERM      = 12;
   localparam int          CHAR_BITS      = 11;         // start, 8 data, parity or stop, stop
   localparam int          PAUSE_CHARS    = 6;
   localparam int          BAUD_DEFAULT   = 38400;
   localparam logic [7:0]  BAUD_CODE_MAX  = 8'h05;
   localparam int          BAUD_RATE [6]  = '{1200, 2400, 19200, 38400, 57600, 115200};

   typedef enum logic [1:0] {MODE_IO, MODE_MOTOR, MODE_MVALVE, MODE_PVALVE} fiosr_mode_e;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } fiosr_req_s;

   typedef struct packed {
      logic        valid;
      logic        hit;
      logic [15:0] rdata;
   } fiosr_rsp_s;
endpackage

// ### rtl/fiosr_pause_timer.sv
// reply delay timer counting whole pauses after the end of a request
`timescale 1ns/1ps
`default_nettype none
module fiosr_pause_timer (
   input  wire logic        clk,        // system clock
   input  wire logic        rst_n,      // synchronised reset, active low
   input  wire logic        start,      // end of received request, pulse
   input  wire logic [7:0]  pauses,     // pause count
   input  wire logic [31:0] pause_cyc,  // clock cycles in one pause
   output logic             busy,       // waiting out the pauses
   output logic             go          // reply may start, pulse
);
   import fiosr_pkg::*;
   typedef enum logic {T_IDLE, T_WAIT} fiosr_tstate_e;
   fiosr_tstate_e state_q;
   logic [7:0]    left_q;
   logic [31:0]   cyc_q;
   logic          go_q;
   // pause length is held from the start so a baud change mid-wait cannot bend the delay
   logic [31:0]   pcyc_q;
   wire           cyc_end = (cyc_q == pcyc_q - 32'h1);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= T_IDLE;
         left_q  <= 8'h00;
         cyc_q   <= 32'h0;
         go_q    <= 1'b0;
         pcyc_q  <= 32'h0;
      end else begin
         go_q <= 1'b0;
         if (start) begin
            // a new request restarts the wait rather than stacking replies
            left_q  <= pauses;
            pcyc_q  <= pause_cyc;
            cyc_q   <= 32'h0;
            state_q <= (pauses == 8'h00) ? T_IDLE : T_WAIT;
            go_q    <= (pauses == 8'h00);
         end else begin
            unique case (state_q)
               T_IDLE: ;
               T_WAIT: begin
                  if (cyc_end) begin
                     cyc_q <= 32'h0;
                     if (left_q == 8'h01) begin
                        go_q    <= 1'b1;
                        state_q <= T_IDLE;
                     end else begin
                        left_q <= left_q - 8'h01;
                     end
                  end else begin
                     cyc_q <= cyc_q + 32'h1;
                  end
               end
            endcase
         end
      end
   end

   assign busy = (state_q == T_WAIT);
   assign go   = go_q;

   // helper: cycles since the last start and the cycle the reply is due
   logic [39:0] elapsed_q;
   logic [39:0] due_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         elapsed_q <= 40'h0;
         due_q     <= 40'h0;
      end else if (start) begin
         elapsed_q <= 40'h1;
         due_q     <= 40'({32'h0, pauses} * {8'h0, pause_cyc}) + 40'h1;
      end else if (elapsed_q != 40'hff_ffff_ffff) begin
         elapsed_q <= elapsed_q + 40'h1;
      end
   end

   property p_zero_go;
      @(posedge clk) disable iff (!rst_n) start && pauses == 8'h00 |=> go && !busy;
   endproperty
   a_zero_go: assert property (p_zero_go) else $error("zero delay reply not immediate");

   property p_go_time;
      @(posedge clk) disable iff (!rst_n) go |-> elapsed_q == due_q;
   endproperty
   a_go_time: assert property (p_go_time) else $error("reply released at wrong time");

   property p_go_single;
      @(posedge clk) disable iff (!rst_n) go && !$past(start) |=> !go;
   endproperty
   a_go_single: assert property (p_go_single) else $error("reply pulse too long");

   c_zero:  cover property (@(posedge clk) disable iff (!rst_n) start && pauses == 8'h00);
   c_multi: cover property (@(posedge clk) disable iff (!rst_n) go && due_q > {8'h0, pause_cyc});
endmodule
`default_nettype wire

// ### rtl/fiosr_top.sv
// field i/o status and communication settings register bank
`timescale 1ns/1ps
`default_nettype none
module fiosr_top
   import fiosr_pkg::*;
#(
   parameter int CLK_HZ = 40_000_000      // shrink in simulation to shorten pauses
) (
   input  wire logic              clk,             // 40 MHz system clock
   input  wire logic              arst_n,          // asynchronous reset, active low
   input  wire fiosr_pkg::fiosr_req_s req,         // register read or write request
   output fiosr_pkg::fiosr_rsp_s  rsp,             // registered read answer
   input  wire fiosr_pkg::fiosr_mode_e mode,       // configured operating mode
   input  wire logic [3:0]        contact_in,      // contact pins, bit0 first contact
   input  wire logic              remote_in,       // local/remote selector pin
   input  wire logic              rx_end,          // received request complete, pulse
   output logic                   reply_go,        // reply may start, pulse
   output logic                   reply_wait,      // reply held back by delay
   output logic [7:0]             baud_code,       // selected baud code
   output logic [31:0]            bit_cyc          // clock cycles per serial bit
);
   import fiosr_pkg::*;

   logic rst_s1_q;
   logic rst_n_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   // pins: two flops before any logic looks at them
   logic [4:0] pin_s1_q;
   logic [4:0] pin_s2_q;
   wire  [4:0] pin_raw = {remote_in, contact_in};
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_sync
         always_ff @(posedge clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
               pin_s1_q[gi] <= 1'b0;
               pin_s2_q[gi] <= 1'b0;
            end else begin
               pin_s1_q[gi] <= pin_raw[gi];
               pin_s2_q[gi] <= pin_s1_q[gi];
            end
         end
      end
   endgenerate

   wire first_contact_input  = pin_s2_q[0];
   wire second_contact_input = pin_s2_q[1];
   wire third_contact_input  = pin_s2_q[2];
   wire fourth_contact_input = pin_s2_q[3];
   wire remote_ctl           = pin_s2_q[4];

   // state word upper nibble; meaning follows the live mode
   wire io_mode    = (mode == MODE_IO);
   wire motor_mode = (mode == MODE_MOTOR);
   wire b15 = io_mode ? first_contact_input : remote_ctl;
   wire b14 = second_contact_input;
   wire b13 = third_contact_input;
   // no fourth contact is defined in the valve modes, so it reads open
   wire b12 = (io_mode || motor_mode) ? fourth_contact_input : 1'b0;
   wire [15:0] state_word = {b15, b14, b13, b12, 12'h000};

   // register access
   logic [15:0] comm_q;
   logic [15:0] comm_d;
   fiosr_rsp_s  rsp_q;
   fiosr_rsp_s  rsp_d;
   wire hit_comm  = (req.addr == REG_COMM_ADDR);
   wire hit_state = (req.addr == REG_STATE_ADDR);
   wire [15:0] rd_mux = hit_comm ? comm_q : (hit_state ? state_word : 16'h0000);
   assign comm_d = (req.wr && hit_comm) ? req.wdata : comm_q;
   assign rsp_d  = '{valid: req.rd, hit: req.rd && (hit_comm || hit_state),
                     rdata: req.rd ? rd_mux : 16'h0000};

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         comm_q <= COMM_RESET;
         rsp_q  <= '0;
      end else begin
         comm_q <= comm_d;
         rsp_q  <= rsp_d;
      end
   end
   assign rsp = rsp_q;

   // baud selection; an unknown code falls back to the default rate
   wire [7:0] baud_sel  = comm_q[BAUD_LSB +: 8];
   wire [7:0] delay_sel = comm_q[DELAY_LSB +: 8];

   function automatic int baud_of(input logic [7:0] code);
      if (code > BAUD_CODE_MAX) begin
         return BAUD_DEFAULT;
      end
      return BAUD_RATE[code[2:0]];
   endfunction

   // a pause is a least time, so its cycle count rounds up
   function automatic logic [31:0] pause_of(input int baud);
      logic [63:0] num;
      num = 64'(CLK_HZ) * 64'(CHAR_BITS * PAUSE_CHARS);
      return 32'((num + 64'(baud) - 64'h1) / 64'(baud));
   endfunction

   wire [31:0] pause_cyc = pause_of(baud_of(baud_sel));
   wire [31:0] bit_cyc_d = 32'(CLK_HZ / baud_of(baud_sel));
   logic [31:0] bit_cyc_q;
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         bit_cyc_q <= 32'h0;
      end else begin
         bit_cyc_q <= bit_cyc_d;
      end
   end
   assign bit_cyc   = bit_cyc_q;
   assign baud_code = baud_sel;

   fiosr_pause_timer u_timer (
      .clk       (clk),
      .rst_n     (rst_n_q),
      .start     (rx_end),
      .pauses    (delay_sel),
      .pause_cyc (pause_cyc),
      .busy      (reply_wait),
      .go        (reply_go)
   );

   property p_rd_answer;
      @(posedge clk) disable iff (!rst_n_q) req.rd |=> rsp.valid ##1 !rsp.valid || $past(req.rd);
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");

   property p_comm_write;
      @(posedge clk) disable iff (!rst_n_q)
         req.wr && hit_comm ##1 req.rd && hit_comm && !req.wr |=> rsp.rdata == $past(req.wdata, 2);
   endproperty
   a_comm_write: assert property (p_comm_write) else $error("settings write not kept");

   property p_baud;
      @(posedge clk) disable iff (!rst_n_q)
         req.wr && hit_comm && req.wdata[15:8] == 8'h03 |=> ##1 bit_cyc == 32'(CLK_HZ / BAUD_DEFAULT);
   endproperty
   a_baud: assert property (p_baud) else $error("bit rate not from high byte");

   property p_b15_io;
      @(posedge clk) disable iff (!rst_n_q)
         req.rd && hit_state && mode == MODE_IO |=> rsp.rdata[15] == $past(pin_s2_q[0]);
   endproperty
   a_b15_io: assert property (p_b15_io) else $error("bit 15 not first contact");

   property p_b15_rem;
      @(posedge clk) disable iff (!rst_n_q)
         req.rd && hit_state && mode != MODE_IO |=> rsp.rdata[15] == $past(pin_s2_q[4]);
   endproperty
   a_b15_rem: assert property (p_b15_rem) else $error("bit 15 not local/remote");

   property p_b14;
      @(posedge clk) disable iff (!rst_n_q)
         req.rd && hit_state |=> rsp.rdata[14] == $past(pin_s2_q[1]);
   endproperty
   a_b14: assert property (p_b14) else $error("bit 14 wrong contact");

   property p_b13;
      @(posedge clk) disable iff (!rst_n_q)
         req.rd && hit_state |=> rsp.rdata[13] == $past(pin_s2_q[2]);
   endproperty
   a_b13: assert property (p_b13) else $error("bit 13 wrong contact");

   property p_b12;
      @(posedge clk) disable iff (!rst_n_q)
         req.rd && hit_state && (mode == MODE_IO || mode == MODE_MOTOR)
         |=> rsp.rdata[12] == $past(pin_s2_q[3]);
   endproperty
   a_b12: assert property (p_b12) else $error("bit 12 wrong contact");

   property p_b12_valve;
      @(posedge clk) disable iff (!rst_n_q)
         req.rd && hit_state && (mode == MODE_MVALVE || mode == MODE_PVALVE) |=> !rsp.rdata[12];
   endproperty
   a_b12_valve: assert property (p_b12_valve) else $error("valve bit 12 not 0");

   property p_low_zero;
      @(posedge clk) disable iff (!rst_n_q)
         req.rd && hit_state |=> rsp.rdata[11:0] == 12'h000;
   endproperty
   a_low_zero: assert property (p_low_zero) else $error("state low bits not zero");

   property p_unmapped;
      @(posedge clk) disable iff (!rst_n_q)
         req.rd && !hit_comm && !hit_state |=> rsp.valid && !rsp.hit && rsp.rdata == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not empty");

   property p_rsp_idle;
      @(posedge clk) disable iff (!rst_n_q) !req.rd |=> !rsp.valid && rsp.rdata == 16'h0000;
   endproperty
   a_rsp_idle: assert property (p_rsp_idle) else $error("answer without a read");

   property p_comm_hold;
      @(posedge clk) disable iff (!rst_n_q) !(req.wr && hit_comm) |=> $stable(comm_q);
   endproperty
   a_comm_hold: assert property (p_comm_hold) else $error("settings drifted");

   property p_baud_dflt;
      @(posedge clk) disable iff (!rst_n_q)
         baud_sel > BAUD_CODE_MAX |=> bit_cyc == 32'(CLK_HZ / BAUD_DEFAULT);
   endproperty
   a_baud_dflt: assert property (p_baud_dflt) else $error("baud code not defaulted");

   property p_reply_end;
      @(posedge clk) disable iff (!rst_n_q)
         reply_wait && !rx_end ##1 !reply_wait |-> reply_go;
   endproperty
   a_reply_end: assert property (p_reply_end) else $error("wait ended without reply");

   c_rd_state: cover property (@(posedge clk) disable iff (!rst_n_q) req.rd && hit_state);
   c_valve:    cover property (@(posedge clk) disable iff (!rst_n_q)
                               req.rd && hit_state && mode == MODE_PVALVE);
   c_reply:    cover property (@(posedge clk) disable iff (!rst_n_q) reply_go);
endmodule
`default_nettype wire

// ### verif/fiosr_master_model.sv
// serial bus master model: ends a request and times the device's reply
`timescale 1ns/1ps
`default_nettype none
module fiosr_master_model (
   input  wire logic clk,         // system clock
   input  wire logic reply_go,    // reply may start, from the device
   input  wire logic reply_wait,  // reply held back, from the device
   output logic      rx_end       // request fully received, pulse
);
   initial rx_end = 1'b0;

   // n counts edges from the rx_end sample to the reply pulse, -1 on no reply
   // w counts the edges that see the wait flag high in between
   // one poll at a time: rx_end is never held across two requests
   task automatic poll(output int n, output int w);
      int i;
      n = -1;
      w = 0;
      @(posedge clk);
      rx_end <= 1'b1;
      @(posedge clk);
      rx_end <= 1'b0;
      // each pass looks at what the next edge will sample
      for (i = 1; i <= 20000; i++) begin
         #1;
         if (reply_wait === 1'b1) begin
            w++;
         end
         if (reply_go === 1'b1) begin
            n = i;
            break;
         end
         @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// self-checking testbench for the field i/o status register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
   import fiosr_pkg::*;
   // small clock rate keeps a full 255-pause wait short
   localparam int CLK = 115200;

   logic        clk, arst_n, remote_in, rx_end, reply_go, reply_wait;
   logic [3:0]  contact_in;
   logic [7:0]  baud_code;
   logic [31:0] bit_cyc;
   fiosr_req_s  req;
   fiosr_rsp_s  rsp;
   fiosr_mode_e mode;
   int          fails, comparisons, m, p, n, w;
   logic [15:0] e;

   fiosr_top #(.CLK_HZ(CLK)) dut (
      .clk(clk), .arst_n(arst_n), .req(req), .rsp(rsp), .mode(mode),
      .contact_in(contact_in), .remote_in(remote_in), .rx_end(rx_end),
      .reply_go(reply_go), .reply_wait(reply_wait), .baud_code(baud_code),
      .bit_cyc(bit_cyc));
   fiosr_master_model master (.clk(clk), .reply_go(reply_go), .reply_wait(reply_wait),
      .rx_end(rx_end));

   function automatic int pause_cyc(input int baud);
      return (CLK * CHAR_BITS * PAUSE_CHARS + baud - 1) / baud;
   endfunction

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      req <= '{1'b0, 1'b1, a, d};
      @(posedge clk);
      req <= '0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [15:0] x, input logic hit);
      @(posedge clk);
      req <= '{1'b1, 1'b0, a, 16'h0000};
      @(posedge clk);
      req <= '0;
      #1;
      `CHK(rsp.valid, 1'b1)
      `CHK(rsp.hit, hit)
      `CHK(rsp.rdata, x)
   endtask

   task automatic test_done;
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      #1_000_000;
      fails++;
      test_done;
   end

   initial begin
      arst_n = 1'b0;
      req = '0;
      mode = MODE_IO;
      contact_in = 4'h0;
      remote_in = 1'b0;
      fails = 0;
      comparisons = 0;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      `CHK(baud_code, 8'h03)
      `CHK(bit_cyc, 32'(CLK / BAUD_DEFAULT))
      rd(REG_COMM_ADDR, COMM_RESET, 1'b1);
      rd(16'h0000, 16'h0000, 1'b0);
      // every mode with each contact seen both open and closed
      for (m = 0; m < 4; m++) begin
         for (p = 0; p < 2; p++) begin
            @(posedge clk);
            mode <= fiosr_mode_e'(m);
            contact_in <= (p == 1) ? 4'h5 : 4'ha;
            remote_in <= 1'(p);
            repeat (3) @(posedge clk);
            if (m == 0)
               e = {contact_in[0], contact_in[1], contact_in[2], contact_in[3], 12'h000};
            else
               e = {remote_in, contact_in[1], contact_in[2],
                    (m == 1) ? contact_in[3] : 1'b0, 12'h000};
            rd(REG_STATE_ADDR, e, 1'b1);
         end
      end
      // state word holds inputs only, a write leaves it alone
      wr(REG_STATE_ADDR, 16'hffff);
      rd(REG_STATE_ADDR, e, 1'b1);
      master.poll(n, w);
      `CHK(n, 1)
      `CHK(w, 0)
      // write and read back to back: the read sees the new settings
      @(posedge clk);
      req <= '{1'b0, 1'b1, REG_COMM_ADDR, 16'h0301};
      @(posedge clk);
      req <= '{1'b1, 1'b0, REG_COMM_ADDR, 16'h0000};
      @(posedge clk);
      req <= '0;
      #1;
      `CHK(rsp.rdata, 16'h0301)
      master.poll(n, w);
      `CHK(n, pause_cyc(BAUD_DEFAULT) + 1)
      `CHK(w, pause_cyc(BAUD_DEFAULT))
      wr(REG_COMM_ADDR, 16'h05ff);
      rd(REG_COMM_ADDR, 16'h05ff, 1'b1);
      @(posedge clk);
      #1;
      `CHK(baud_code, 8'h05)
      `CHK(bit_cyc, 32'(CLK / BAUD_RATE[5]))
      master.poll(n, w);
      `CHK(n, 255 * pause_cyc(BAUD_RATE[5]) + 1)
      `CHK(w, 255 * pause_cyc(BAUD_RATE[5]))
      // every baud code; a code past the table falls back to the default rate
      for (m = 0; m < 7; m++) begin
         wr(REG_COMM_ADDR, {8'(m), 8'h00});
         @(posedge clk);
         #1;
         `CHK(baud_code, 8'(m))
         if (m <= 5)
            `CHK(bit_cyc, 32'(CLK / BAUD_RATE[m]))
         else
            `CHK(bit_cyc, 32'(CLK / BAUD_DEFAULT))
      end
      test_done;
   end
endmodule
`default_nettype wire
